//--- hw/ecc_edge_clock_control.v
`timescale 1ns/1ps
`include "ecc_map.vh"
module ecc_edge_clock_control #(
    parameter       DIV_MODE   = `ECC_DIV_2,  // Ratio code
    parameter       GSR_LINK   = `ECC_GSR_OFF, // Global reset link option
    parameter [1:0] SIDE_COUNT = 2'd2,        // Sides with dividers
    parameter [1:0] DIV_PER    = 2'd2         // Dividers per side
) (
    input  wire       ref_clk,            // Block clock, unused by clock paths
    input  wire       rst_n,              // Global reset, active low
    input  wire [3:0] divider_in,         // Divider source clocks
    input  wire [3:0] divider_rst,        // Divider resets, active high
    input  wire [3:0] word_align,         // Word align requests
    output wire [3:0] divided_out,        // Divided clocks
    input  wire [7:0] edge_source,        // Edge sources, four per side
    output wire [3:0] edge_net_first,     // Bank first net, [side*2+bank]
    output wire [3:0] edge_net_second,    // Bank second net
    input  wire [1:0] first_source,       // Bridge input 0 per side
    input  wire [1:0] second_source,      // Bridge input 1 per side
    input  wire [1:0] edge_bridge_select, // Bridge select per side
    output wire [1:0] bridge_out,         // Bridge output, needs stop gate
    input  wire [1:0] gate_in,            // Stop gate input clocks
    input  wire [1:0] gate_stop,          // Stop request, high stops
    output wire [1:0] gated_out           // Gated clocks
);
    genvar i;
    generate
        for (i = 0; i < SIDE_COUNT * DIV_PER; i = i + 1) begin : g_div
            reg  [`ECC_PH_W-1:0] ph_q;
            reg                  pos_q;
            reg                  neg_q;
            reg                  skip_q;
            reg                  al_s1_q;
            reg                  al_s2_q;
            reg                  al_old_q;
            wire                 rst_any;
            wire                 gsr_hit;
            wire [`ECC_PH_W-1:0] last;
            reg  [`ECC_PH_W-1:0] ph_d;
            reg                  pos_d;
            reg                  neg_d;
            reg                  skip_d;
            // global reset joins only when the option is set
            assign gsr_hit = (GSR_LINK == `ECC_GSR_ON) & ~rst_n;
            assign rst_any = divider_rst[i] | gsr_hit;
            // 2: 2 phases; 3.5: 7 phases (input cycles) over two periods
            assign last = (DIV_MODE == `ECC_DIV_3P5) ? `ECC_PH_35_LAST : `ECC_PH_2_LAST;
            // Next phase and output levels
            always @* begin
                // rising align swallows one input cycle
                skip_d = al_s2_q & ~al_old_q;
                ph_d   = ph_q;
                pos_d  = 1'b0;
                neg_d  = 1'b0;
                if (!skip_q) begin
                    ph_d = (ph_q == last) ? {`ECC_PH_W{1'b0}} : ph_q + 1'b1;
                end
                if (DIV_MODE == `ECC_DIV_3P5) begin
                    // two output periods in seven input cycles
                    // rising stage high over phases 0 and 1,
                    // falling stage high from mid phase 3 to mid phase 5
                    case (ph_d)
                        3'd0:    pos_d = 1'b1;
                        3'd1:    pos_d = 1'b1;
                        default: pos_d = 1'b0;
                    endcase
                    case (ph_q)
                        3'd3:    neg_d = 1'b1;
                        3'd4:    neg_d = 1'b1;
                        default: neg_d = 1'b0;
                    endcase
                end else begin
                    // ratio 2: high on every other input cycle
                    case (ph_q)
                        3'd0:    pos_d = 1'b1;
                        default: pos_d = 1'b0;
                    endcase
                end
            end
            always @(posedge divider_in[i] or posedge rst_any) begin
                if (rst_any) begin
                    ph_q     <= {`ECC_PH_W{1'b0}};
                    pos_q    <= 1'b0;
                    al_s1_q  <= 1'b0;
                    al_s2_q  <= 1'b0;
                    al_old_q <= 1'b0;
                    skip_q   <= 1'b0;
                end else begin
                    al_s1_q  <= word_align[i];
                    al_s2_q  <= al_s1_q;
                    al_old_q <= al_s2_q;
                    skip_q   <= skip_d;
                    ph_q     <= ph_d;
                    pos_q    <= pos_d;
                end
            end
            // Falling stage supplies the half cycle for 3.5
            // Duty is not 50%, the sink only needs the edges
            always @(negedge divider_in[i] or posedge rst_any) begin
                if (rst_any) begin
                    neg_q <= 1'b0;
                end else begin
                    neg_q <= neg_d;
                end
            end
            assign divided_out[i] = (DIV_MODE == `ECC_DIV_3P5) ? (pos_q | neg_q) : pos_q;
        end
    endgenerate
    // per side: sources 0,1 upper bank, 2,3 lower bank
    generate
        for (i = 0; i < 2; i = i + 1) begin : g_side
            wire bridged;
            // non-glitchless select, 0 first, 1 second
            // A select change while either source is high can slice a pulse;
            // the stop gate after it is where a clean start is made
            assign bridged = (edge_bridge_select[i] == `ECC_SEL_SECOND) ?
                             second_source[i] : first_source[i];
            assign bridge_out[i] = bridged;
            // left takes second nets, right takes first nets
            if (i == 0) begin : g_left
                assign edge_net_first[0]  = edge_source[0];
                assign edge_net_first[1]  = edge_source[2];
                assign edge_net_second[0] = `ECC_LEFT_NET ? edge_source[1] : 1'b0;
                assign edge_net_second[1] = `ECC_LEFT_NET ? edge_source[3] : 1'b0;
            end else begin : g_right
                assign edge_net_first[2]  = `ECC_RIGHT_NET ? 1'b0 : edge_source[4];
                assign edge_net_first[3]  = `ECC_RIGHT_NET ? 1'b0 : edge_source[6];
                assign edge_net_second[2] = edge_source[5];
                assign edge_net_second[3] = edge_source[7];
            end
        end
    endgenerate
    // Bridged net is bridge_out; the integrator routes it to gate_in of the stop gate below
    generate
        for (i = 0; i < 2; i = i + 1) begin : g_gate
            reg [`ECC_SYNC_STAGES-1:0] sync_q;
            reg [2:0]                  cnt_q;
            reg                        run_q;
            reg                        en_q;
            reg [1:0]                  rel_q;
            reg [2:0]                  cnt_d;
            reg                        run_d;
            wire                       live;
            // Reset is let go on a gate edge so a count never starts half way
            always @(posedge gate_in[i] or negedge rst_n) begin
                if (!rst_n) begin
                    rel_q <= 2'b00;
                end else begin
                    rel_q <= {rel_q[0], 1'b1};
                end
            end
            assign live = rel_q[1];
            // fourth edge: two sync edges, then two counted ones
            always @* begin
                cnt_d = 3'd0;
                run_d = run_q;
                if (live && (sync_q[1] == run_q)) begin
                    if (cnt_q == `ECC_STOP_EDGES - 3'd3) begin
                        run_d = ~sync_q[1];
                    end else begin
                        cnt_d = cnt_q + 3'd1;
                    end
                end
            end
            // two-stage synchroniser on the gate clock
            // A stop shorter than the sync and count window is lost
            always @(posedge gate_in[i] or negedge rst_n) begin
                if (!rst_n) begin
                    sync_q <= {`ECC_SYNC_STAGES{1'b0}};
                    cnt_q  <= 3'd0;
                    run_q  <= 1'b1;
                end else begin
                    sync_q <= {sync_q[0], gate_stop[i]};
                    cnt_q  <= cnt_d;
                    run_q  <= run_d;
                end
            end
            // enable changes only while the clock is low
            always @(negedge gate_in[i] or negedge rst_n) begin
                if (!rst_n) begin
                    en_q <= 1'b1;
                end else begin
                    en_q <= run_q;
                end
            end
            assign gated_out[i] = gate_in[i] & en_q;
        end
    endgenerate
endmodule

//--- hw/ecc_map.vh
`ifndef ECC_MAP_VH
`define ECC_MAP_VH
// Divider ratio codes
`define ECC_DIV_2        1'b0
`define ECC_DIV_3P5      1'b1
// Global reset link option codes
`define ECC_GSR_OFF      1'b0
`define ECC_GSR_ON       1'b1
// Bridge select codes
`define ECC_SEL_FIRST    1'b0
`define ECC_SEL_SECOND   1'b1
// Stop gate edge counts
`define ECC_STOP_EDGES   3'd4
`define ECC_SYNC_STAGES  2
// Bridge edge net usage per side
`define ECC_LEFT_NET     1'b1
`define ECC_RIGHT_NET    1'b0
// Divider phase counter
`define ECC_PH_W         3
`define ECC_PH_2_LAST    3'd1
`define ECC_PH_35_LAST   3'd6
`endif

//--- tb/ecc_core_model.sv
`timescale 1ns/1ps
module ecc_core_model (
    input  wire       clk,        // Gate clock seen by core
    input  wire [1:0] req,        // Stop wishes from bench
    output reg  [1:0] stop = 2'h0 // Level stop, high is off
);
    // Launch after a rising edge, like fabric flops
    always @(posedge clk) stop <= req;
endmodule

//--- tb/ecc_edge_clock_control_asserts.sv
`timescale 1ns/1ps
module ecc_asserts #(parameter DIV_MODE = 0) (
    input wire       ref_clk, rst_n,                              // Clock, reset
    input wire [3:0] divider_in, divider_rst, word_align,         // Dividers
    input wire [3:0] divided_out, edge_net_first, edge_net_second, // Outputs
    input wire [7:0] edge_source,                                 // Sources
    input wire [1:0] first_source, second_source, edge_bridge_select, // Bridge
    input wire [1:0] bridge_out, gate_in, gate_stop, gated_out    // Gates
);
    property p_mux; @(posedge ref_clk) disable iff (!rst_n) bridge_out ==
        (edge_bridge_select & second_source | ~edge_bridge_select & first_source); endproperty
    a_mux: assert property (p_mux) else $error("bridge wrong");
    property p_first; @(posedge ref_clk) disable iff (!rst_n) edge_net_first ==
        {edge_source[6], edge_source[4], edge_source[2], edge_source[0]}; endproperty
    a_first: assert property (p_first) else $error("first nets wrong");
    property p_second; @(posedge ref_clk) disable iff (!rst_n) edge_net_second ==
        {edge_source[7], edge_source[5], edge_source[3], edge_source[1]}; endproperty
    a_second: assert property (p_second) else $error("second nets wrong");
    property p_drst; @(posedge ref_clk) disable iff (!rst_n)
        (divided_out & divider_rst) == 4'h0; endproperty
    a_drst: assert property (p_drst) else $error("divider not held low");
    // Gate output may only be high while its input is high
    property p_glitch; @(posedge ref_clk) disable iff (!rst_n)
        (gated_out & ~gate_in) == 2'h0; endproperty
    a_glitch: assert property (p_glitch) else $error("gate glitch");
    property p_stop; @(negedge gate_in[0]) disable iff (!rst_n)
        gate_stop[0] [*6] |-> !gated_out[0]; endproperty
    a_stop: assert property (p_stop) else $error("gate not stopped");
    property p_run; @(negedge gate_in[0]) disable iff (!rst_n)
        !gate_stop[0] [*6] |-> gated_out[0]; endproperty
    a_run: assert property (p_run) else $error("gate not running");
    property p_div2; @(negedge divider_in[0]) disable iff (divider_rst[0])
        (DIV_MODE == 0 && !word_align[0]) [*3] |-> divided_out[0] != $past(divided_out[0]);
    endproperty
    a_div2: assert property (p_div2) else $error("ratio two wrong");
endmodule
bind ecc_edge_clock_control ecc_asserts #(.DIV_MODE(DIV_MODE)) chk_u (.*);

//--- tb/edge_clock_control_tb.sv
`timescale 1ns/1ps
module edge_clock_control_tb;
    reg  [3:0] divider_in = 4'h0, divider_rst = 4'hf, word_align = 4'h0;
    reg  [7:0] edge_source = 8'h00;
    reg  [1:0] first_source = 2'h0, second_source = 2'h0, edge_bridge_select = 2'h0, req = 2'h0;
    reg        ref_clk = 1'b0, rst_n = 1'b0;
    wire [3:0] divided_out, edge_net_first, edge_net_second;
    wire [1:0] bridge_out, gate_stop, gated_out;
    wire [3:0] div35;
    integer    rises35 = 0;
    wire [1:0] gate_in = bridge_out;
    wire [1:0] mux_exp = edge_bridge_select & second_source | ~edge_bridge_select & first_source;
    integer    failures = 0, checks = 0, rises = 0, i, k;
    ecc_edge_clock_control dut_u (.*);
    ecc_edge_clock_control #(.DIV_MODE(1'b1)) dut35_u (.*, .divided_out(div35),
        .edge_net_first(), .edge_net_second(), .bridge_out(), .gated_out());
    always @(posedge div35[0]) rises35 = rises35 + 1;
    ecc_core_model core_u (.clk(bridge_out[0]), .req(req), .stop(gate_stop));
    initial forever #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) {first_source, divider_in} <= ~{first_source, divider_in};
    always @(posedge divided_out[0]) rises = rises + 1;
    task chk(input [3:0] got, input [3:0] exp);
        checks = checks + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task conclude;
        if (failures == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #10000 failures = failures + 1;
        conclude;
    end
    initial begin
        void'($urandom(32'h765ee2cc));
        repeat (3) @(negedge ref_clk);
        chk(divided_out, 4'h0);
        @(posedge ref_clk) rst_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
        divider_rst <= 4'h0;
        rises = 0;
        rises35 = 0;
        for (i = 0; i < 40; i = i + 1) begin
            // Side 0 kept clean: its gate clock also clocks the core model
            @(posedge ref_clk) {edge_source, second_source, edge_bridge_select} <= 12'($urandom) & 12'hffa;
            @(negedge ref_clk) chk(bridge_out, mux_exp);
            for (k = 0; k < 4; k = k + 1)
                chk({edge_net_second[k], edge_net_first[k]}, edge_source[2*k+:2]);
        end
        chk(rises > 8 && rises < 12, 4'h1);
        chk(rises35 > 4 && rises35 < 7, 4'h1);
        @(posedge ref_clk) {word_align[1], edge_bridge_select} <= 3'h4;
        repeat (8) @(posedge ref_clk);
        word_align[1] <= 1'b0;
        repeat (8) @(negedge ref_clk);
        chk(divided_out[1] ^ divided_out[0], 4'h1);
        @(posedge ref_clk) req <= 2'h3;
        repeat (12) @(negedge ref_clk);
        chk(gated_out, 4'h0);
        @(negedge ref_clk) chk(gated_out, 4'h0);
        @(posedge ref_clk) req <= 2'h0;
        repeat (12) @(negedge ref_clk);
        chk(gated_out, bridge_out);
        @(negedge ref_clk) chk(gated_out, bridge_out);
        conclude;
    end
endmodule
